// ===== bench/tb.sv
// Self-checking bench of the FIFO status block
`timescale 1ns/1ps
`include "ufs_regs.svh"
module tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata;
    logic reg_write = 1'b0, reg_read = 1'b0, tx_valid = 1'b0, tx_ready, rx_valid;
    logic rx_ready = 1'b0, serial_clk_mode = 1'b0, rx_line, tx_line, busy, send = 1'b0;
    ufs_pkg::ufs_byte_t tx_data = 8'h00, rx_data, send_byte = 8'h00, got_byte;
    ufs_pkg::ufs_div_t baud_div = 16'h0010;
    int bad_count = 0, tests_run = 0, n, t0;
    always #4 clk_sys = ~clk_sys;
    ufs_status i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .baud_div(baud_div),
        .serial_clk_mode(serial_clk_mode), .rx_line(rx_line), .tx_line(tx_line), .busy(busy));
    ufs_partner i_far (.clk_sys(clk_sys), .baud_div(baud_div), .tx_line(tx_line),
        .rx_line(rx_line), .send(send), .send_byte(send_byte), .got_byte(got_byte));
    task final_report;
        if (bad_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task wait_busy(input logic v, output int c);
        c = 0;
        while (busy !== v) begin
            @(posedge clk_sys);
            #1 c++;
            if (c > 8000) begin
                chk(32'h1, 32'h0);
                final_report;
            end
        end
    endtask
    task push(input ufs_pkg::ufs_byte_t d);
        @(posedge clk_sys);
        tx_valid <= 1'b1;
        tx_data <= d;
        #1 n = 0;
        while (tx_ready !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1 n++;
        end
        if (n >= 50) chk(32'h1, 32'h0);
        @(posedge clk_sys);
        tx_valid <= 1'b0;
    endtask
    task far_send(input ufs_pkg::ufs_byte_t b, input int hold);
        @(posedge clk_sys);
        send <= 1'b1;
        send_byte <= b;
        @(posedge clk_sys);
        send <= 1'b0;
        repeat (hold) @(posedge clk_sys);
        #1;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(`UFS_STATUS_ADDR, 32'h00000006);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_wdata <= 32'hFFFFFFFF;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        rd(`UFS_STATUS_ADDR, 32'h00000006);
        rd(`UFS_STATUS_ADDR + 32'h4, 32'h00000000);
        // Fill the transmit path until it refuses
        @(posedge clk_sys);
        tx_valid <= 1'b1;
        n = 0;
        repeat (40) begin
            #1 if (tx_ready) n++;
            @(posedge clk_sys);
            tx_data <= n[7:0];
        end
        tx_valid <= 1'b0;
        chk(n, 32'h00000013);
        rd(`UFS_STATUS_ADDR, 32'h00000001);
        wait_busy(1'b0, t0);
        rd(`UFS_STATUS_ADDR, 32'h00000006);
        chk(got_byte, n - 1);
        // Start bit not seen before mid-bit
        far_send(8'h5A, 2);
        chk(busy, 1'b0);
        repeat (60) @(posedge clk_sys);
        #1 chk(busy, 1'b1);
        repeat (100) @(posedge clk_sys);
        for (int i = 0; i < 18; i++) far_send(8'(8'hA0 + i), 160);
        rd(`UFS_STATUS_ADDR, 32'h0000001F);
        @(posedge clk_sys);
        rx_ready <= 1'b1;
        #1 chk({rx_valid, rx_data}, 9'h15A);
        @(posedge clk_sys);
        rx_ready <= 1'b0;
        rd(`UFS_STATUS_ADDR, 32'h0000000F);
        @(posedge clk_sys);
        rx_ready <= 1'b1;
        #1 wait_busy(1'b0, t0);
        rd(`UFS_STATUS_ADDR, 32'h00000006);
        // Busy delay with the separate serial clock
        push(8'h11);
        #1 wait_busy(1'b1, t0);
        wait_busy(1'b0, n);
        @(posedge clk_sys);
        serial_clk_mode <= 1'b1;
        push(8'h22);
        #1 wait_busy(1'b1, n);
        chk(n, t0 + 3);
        final_report;
    end
endmodule

// ===== bench/ufs_partner.sv
// Remote serial device on the far side of the line
`timescale 1ns/1ps
module ufs_partner (
    // Clock and line setting
    input wire logic clk_sys,
    input wire ufs_pkg::ufs_div_t baud_div,
    // Serial lines seen from the remote end
    input wire logic tx_line,
    output logic rx_line,
    // Bench control
    input wire logic send,
    input wire ufs_pkg::ufs_byte_t send_byte,
    output ufs_pkg::ufs_byte_t got_byte
);
    ufs_pkg::ufs_byte_t sh;
    ufs_pkg::ufs_byte_t r;
    initial begin
        rx_line = 1'b1;
        got_byte = 8'h00;
    end
    // One 8N1 frame, low bit first, line idles high
    always @(posedge clk_sys) begin
        if (send) begin
            sh = send_byte;
            rx_line <= 1'b0;
            repeat (baud_div) @(posedge clk_sys);
            for (int i = 0; i < 9; i++) begin
                rx_line <= (i < 8) ? sh[i] : 1'b1;
                repeat (baud_div) @(posedge clk_sys);
            end
        end
    end
    // Incoming frames are sampled at mid-bit
    always @(negedge tx_line) begin
        repeat (baud_div / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (baud_div) @(posedge clk_sys);
            r[i] = tx_line;
        end
        got_byte = r;
    end
endmodule

// ===== bench/ufs_status_monitor.sv
// Port checker of the FIFO status block
`timescale 1ns/1ps
`include "ufs_regs.svh"
module ufs_status_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // Transmit side, mode and status
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic serial_clk_mode,
    input wire logic tx_line,
    input wire logic busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_rd;
        reg_read && reg_addr == `UFS_STATUS_ADDR;
    endsequence
    sequence s_push;
        tx_valid && tx_ready;
    endsequence
    property p_rsv;
        reg_rdata[31:5] == 27'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_quiet;
        !(reg_read && reg_addr == `UFS_STATUS_ADDR) |=> reg_rdata == 32'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("data without read");
    property p_rxf;
        s_rd |=> (!reg_rdata[4] || reg_rdata[3]);
    endproperty
    a_rxf: assert property (p_rxf) else $error("rx full but empty");
    property p_txe;
        s_rd |=> (!reg_rdata[2] || reg_rdata[1]);
    endproperty
    a_txe: assert property (p_txe) else $error("tx empty but full");
    property p_txb;
        $fell(tx_line) |-> ##[0:4] busy;
    endproperty
    a_txb: assert property (p_txb) else $error("sending while idle");
    property p_bfall;
        $fell(busy) |-> tx_line && $past(tx_line);
    endproperty
    a_bfall: assert property (p_bfall) else $error("idle mid frame");
    property p_push;
        s_push ##0 !serial_clk_mode |-> ##[1:3] busy;
    endproperty
    a_push: assert property (p_push) else $error("busy late");
    property p_slow;
        s_push ##0 (serial_clk_mode && !busy) |=> !busy [*2];
    endproperty
    a_slow: assert property (p_slow) else $error("busy early");
endmodule
bind ufs_status ufs_status_monitor i_mon (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .serial_clk_mode(serial_clk_mode), .tx_line(tx_line), .busy(busy));

// ===== verilog/ufs_pkg.sv
// Types of the FIFO status block
package ufs_pkg;
    typedef logic [4:0] ufs_level_t;
    typedef logic [7:0] ufs_byte_t;
    typedef logic [15:0] ufs_div_t;
    typedef enum logic [1:0] {UFS_RX_IDLE, UFS_RX_START, UFS_RX_DATA} ufs_rx_state_t;
endpackage

// ===== verilog/ufs_regs.svh
// Register offsets, field positions, reset values and timing counts of the FIFO status block
`ifndef UFS_REGS_SVH
`define UFS_REGS_SVH
`define UFS_STATUS_ADDR 32'h5002017C
`define UFS_BIT_RFF 4
`define UFS_BIT_RFNE 3
`define UFS_BIT_TFE 2
`define UFS_BIT_TFNF 1
`define UFS_BIT_BUSY 0
`define UFS_STATUS_RESET 32'h00000006
`define UFS_FIFO_DEPTH 16
`define UFS_SYNC_STAGES 3
`endif

// ===== verilog/ufs_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module ufs_skid (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire ufs_pkg::ufs_byte_t in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output ufs_pkg::ufs_byte_t out_data,
    output logic [1:0] count
);
    typedef struct packed {
        ufs_pkg::ufs_byte_t d0;
        ufs_pkg::ufs_byte_t d1;
        logic [1:0] n;
        logic rdy;
        logic vld;
    } ufs_skid_st_t;
    ufs_skid_st_t s;
    ufs_skid_st_t next_s;
    logic push;
    logic pop;
    // Handshake levels are kept in flops so the top ports come from registers
    assign in_ready = s.rdy;
    assign out_valid = s.vld;
    assign out_data = s.d0;
    assign count = s.n;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        next_s = s;
        if (pop) begin
            next_s.d0 = s.d1;
        end
        if (push) begin
            if (s.n == 2'h0 || (s.n == 2'h1 && pop)) begin
                next_s.d0 = in_data;
            end else begin
                next_s.d1 = in_data;
            end
        end
        next_s.n = s.n + {1'b0, push} - {1'b0, pop};
        next_s.rdy = (next_s.n != 2'h2);
        next_s.vld = (next_s.n != 2'h0);
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.rdy <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ===== verilog/ufs_status.sv
// UART FIFO status word with the FIFOs, line activity and busy flag behind it
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "ufs_regs.svh"
// What this block does
// RQ1: Status bit 4 is 1 while every receive FIFO entry is occupied.
// RQ2: Status bit 3 is 1 while receive FIFO holds a character; resets 0.
// RQ3: Status bit 2 is 1 while transmit FIFO is empty; resets 1.
// RQ4: Status bit 1 is 1 while transmit FIFO has a free slot; resets 1.
// RQ5: Status bit 0 is set during a serial transfer, clear when idle; resets 0.
// RQ6: Busy reads 0 with everything empty even if a start bit just began.
// RQ7: Start bit accepted only at mid-bit, set by the baud divisor.
// RQ8: With the separate serial clock, busy asserts several cycles later.
// RQ9: Bits 31 to 5 are reserved, read zero, writes ignored.
// RQ10: Both FIFOs hold sixteen character entries.
// RQ11: Flags follow FIFO pointer changes within one clock.
module ufs_status (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Transmit queue fill side and receive queue drain side
    input wire logic tx_valid,
    output logic tx_ready,
    input wire ufs_pkg::ufs_byte_t tx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output ufs_pkg::ufs_byte_t rx_data,
    // Configuration
    input wire ufs_pkg::ufs_div_t baud_div,
    input wire logic serial_clk_mode,
    // Serial line
    input wire logic rx_line,
    output logic tx_line,
    // Status levels
    output logic busy
);
    typedef struct packed {
        ufs_pkg::ufs_level_t tx_cnt;
        logic [3:0] tx_rd;
        logic [3:0] tx_wr;
        ufs_pkg::ufs_level_t rx_cnt;
        logic [3:0] rx_rd;
        logic [3:0] rx_wr;
        logic tx_act;
        ufs_pkg::ufs_div_t tx_tick;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        ufs_pkg::ufs_rx_state_t rx_st;
        ufs_pkg::ufs_div_t rx_tick;
        logic [3:0] rx_bit;
        ufs_pkg::ufs_byte_t rx_sh;
        logic [`UFS_SYNC_STAGES-1:0] busy_sync;
        logic busy;
        logic tx_line;
        logic [31:0] rdata;
    } ufs_st_t;
    ufs_st_t s;
    ufs_st_t next_s;
    ufs_pkg::ufs_byte_t tx_mem [0:`UFS_FIFO_DEPTH-1];
    ufs_pkg::ufs_byte_t rx_mem [0:`UFS_FIFO_DEPTH-1];
    localparam ufs_pkg::ufs_level_t DEPTH = 5'(`UFS_FIFO_DEPTH);
    logic bt_valid;
    logic bt_ready;
    ufs_pkg::ufs_byte_t bt_data;
    logic br_valid;
    logic br_ready;
    ufs_pkg::ufs_byte_t br_data;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic rx_done;
    logic [4:0] flags;
    logic busy_raw;
    ufs_pkg::ufs_div_t half_div;
    ufs_pkg::ufs_div_t full_div;
    ufs_pkg::ufs_level_t tx_cnt_nx;
    ufs_pkg::ufs_level_t rx_cnt_nx;
    logic busy_nx;
    // Transmit queue entry buffer
    ufs_skid u_tx_buf (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(bt_valid),
        .out_ready(bt_ready),
        .out_data(bt_data),
        .count()
    );
    // Receive queue exit buffer
    ufs_skid u_rx_buf (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(br_valid),
        .in_ready(br_ready),
        .in_data(br_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data),
        .count()
    );
    assign full_div = (baud_div == 16'h0000) ? 16'h0001 : baud_div;
    assign half_div = full_div >> 1;
    assign bt_ready = (s.tx_cnt != DEPTH); // RQ10
    assign tx_push = bt_valid && bt_ready;
    assign tx_pop = !s.tx_act && (s.tx_cnt != 5'h00);
    assign rx_done = (s.rx_st == ufs_pkg::UFS_RX_DATA) && (s.rx_tick == 16'h0000)
        && (s.rx_bit == 4'h8);
    // A character arriving on a full queue is dropped
    assign rx_push = rx_done && rx_line && (s.rx_cnt != DEPTH);
    assign br_valid = (s.rx_cnt != 5'h00);
    assign br_data = rx_mem[s.rx_rd];
    assign rx_pop = br_valid && br_ready;
    // FIFO flags follow the next counts so a read sees the latest push or pop; busy follows the current state
    always_comb begin
        flags[`UFS_BIT_RFF] = (rx_cnt_nx == DEPTH); // RQ1
        flags[`UFS_BIT_RFNE] = (rx_cnt_nx != 5'h00); // RQ2
        flags[`UFS_BIT_TFE] = (tx_cnt_nx == 5'h00); // RQ3
        flags[`UFS_BIT_TFNF] = (tx_cnt_nx != DEPTH); // RQ4
        flags[`UFS_BIT_BUSY] = busy_nx; // RQ11
    end
    // Start bit not yet qualified does not count as activity
    assign busy_raw = s.tx_act || (s.tx_cnt != 5'h00) || (s.rx_cnt != 5'h00)
        || (s.rx_st == ufs_pkg::UFS_RX_DATA); // RQ6 RQ5
    assign tx_cnt_nx = s.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
    assign rx_cnt_nx = s.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
    // Serial clock mode holds off assertion until the delay chain agrees
    assign busy_nx = busy_raw
        && (!serial_clk_mode || s.busy_sync[`UFS_SYNC_STAGES-1]); // RQ8
    always_comb begin
        next_s = s;
        next_s.tx_cnt = tx_cnt_nx;
        next_s.rx_cnt = rx_cnt_nx;
        if (tx_push) begin
            next_s.tx_wr = s.tx_wr + 4'h1;
        end
        if (rx_push) begin
            next_s.rx_wr = s.rx_wr + 4'h1;
        end
        if (rx_pop) begin
            next_s.rx_rd = s.rx_rd + 4'h1;
        end
        // Transmitter: start, eight data bits, stop
        if (tx_pop) begin
            next_s.tx_rd = s.tx_rd + 4'h1;
            next_s.tx_act = 1'b1;
            next_s.tx_sh = {1'b1, tx_mem[s.tx_rd], 1'b0};
            next_s.tx_bit = 4'h0;
            next_s.tx_tick = full_div - 16'h0001;
            next_s.tx_line = 1'b0;
        end else if (s.tx_act) begin
            if (s.tx_tick == 16'h0000) begin
                next_s.tx_tick = full_div - 16'h0001;
                if (s.tx_bit == 4'h9) begin
                    next_s.tx_act = 1'b0;
                    next_s.tx_line = 1'b1;
                end else begin
                    next_s.tx_bit = s.tx_bit + 4'h1;
                    next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
                    next_s.tx_line = s.tx_sh[1];
                end
            end else begin
                next_s.tx_tick = s.tx_tick - 16'h0001;
            end
        end
        // Receiver qualifies the start bit at its midpoint
        case (s.rx_st)
            ufs_pkg::UFS_RX_IDLE: begin
                if (!rx_line) begin
                    next_s.rx_st = ufs_pkg::UFS_RX_START;
                    next_s.rx_tick = half_div;
                end
            end
            ufs_pkg::UFS_RX_START: begin
                if (s.rx_tick != 16'h0000) begin
                    next_s.rx_tick = s.rx_tick - 16'h0001;
                end else if (!rx_line) begin
                    next_s.rx_st = ufs_pkg::UFS_RX_DATA; // RQ7
                    next_s.rx_tick = full_div - 16'h0001;
                    next_s.rx_bit = 4'h0;
                end else begin
                    next_s.rx_st = ufs_pkg::UFS_RX_IDLE;
                end
            end
            ufs_pkg::UFS_RX_DATA: begin
                if (s.rx_tick != 16'h0000) begin
                    next_s.rx_tick = s.rx_tick - 16'h0001;
                end else if (s.rx_bit == 4'h8) begin
                    next_s.rx_st = ufs_pkg::UFS_RX_IDLE;
                end else begin
                    next_s.rx_tick = full_div - 16'h0001;
                    next_s.rx_bit = s.rx_bit + 4'h1;
                    next_s.rx_sh = {rx_line, s.rx_sh[7:1]};
                end
            end
            default: begin
                next_s.rx_st = ufs_pkg::UFS_RX_IDLE;
            end
        endcase
        // Serial clock mode delays assertion only; release stays immediate
        next_s.busy_sync = {s.busy_sync[`UFS_SYNC_STAGES-2:0], busy_raw};
        next_s.busy = busy_nx; // RQ5 RQ8
        // Read-only word; writes have no effect
        next_s.rdata = 32'h00000000;
        if (reg_read && reg_addr == `UFS_STATUS_ADDR) begin
            next_s.rdata = {27'h0000000, flags}; // RQ9
        end
    end
    always_ff @(posedge clk_sys) begin
        if (tx_push) begin
            tx_mem[s.tx_wr] <= bt_data;
        end
        if (rx_push) begin
            rx_mem[s.rx_wr] <= s.rx_sh;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.tx_line <= 1'b1;
            s.rdata <= 32'h00000000;
        end else begin
            s <= next_s;
        end
    end
    assign reg_rdata = s.rdata;
    assign tx_line = s.tx_line;
    assign busy = s.busy;
endmodule
